//--- reset_entry_pkg.sv
// constants shared by the switch reset-entry logic and the board supervisor
// Summary of operation
// - switch takes two resets, the board reset and the test reset
// - board reset release synchronized on register clock
// - supervisor holds board reset 1 ms minimum
// - register clock runs before reset hold starts
// - test reset asserted with board reset at power-up
// - later board reset pulses need no test reset
// - test reset driven by AND of both resets
// - option pins double sampled at reset release
// - option pins held ten cycles after release
// - i2c clock is register clock divided by 1000
// - only i2c clock generation uses divided clock
// - register logic clocked directly by register clock
// - fabric logic clocked by serial reference clock
// - transmit ports clocked by serial reference clock
package reset_entry_pkg;
    localparam int unsigned CLK_PERIOD_NS         = 100;
    localparam int unsigned RESET_HOLD_NS         = 1000000;
    localparam int unsigned RESET_HOLD_CYCLES     = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CNT_W            = 14;
    localparam int unsigned STRAP_HOLD_NS         = 100;
    localparam int unsigned STRAP_HOLD_TIME_CYC   = (STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STRAP_HOLD_PIN_CYC    = 10;
    localparam int unsigned STRAP_HOLD_CYCLES     = (STRAP_HOLD_TIME_CYC > STRAP_HOLD_PIN_CYC) ?
                                                    STRAP_HOLD_TIME_CYC : STRAP_HOLD_PIN_CYC;
    localparam int unsigned STRAP_CNT_W           = 4;
    localparam int unsigned STRAP_W               = 2;
    localparam int unsigned I2C_DIVIDE            = 1000;
    localparam int unsigned I2C_CNT_W             = 10;
    localparam logic [I2C_CNT_W-1:0] I2C_HALF_LAST = I2C_CNT_W'(I2C_DIVIDE / 2 - 1);
    localparam int unsigned SER_DOMAINS           = 2;
    localparam int unsigned SER_FABRIC            = 0;
    localparam int unsigned SER_TX                = 1;
    localparam logic [STRAP_W-1:0] STRAP_RESET    = 2'h0;

    typedef enum logic [0:0] {
        SUP_HOLD = 1'b0,
        SUP_RUN  = 1'b1
    } sup_state_t;
endpackage : reset_entry_pkg

//--- reset_entry_if.sv
// board-level signals between the supervisor and the switch reset entry
`timescale 1ns/1ns
interface reset_entry_if;
    logic                                board_reset_n;
    logic                                test_reset_n;
    logic [reset_entry_pkg::STRAP_W-1:0] straps;
    logic                                ser_clk;

    modport device (
        input board_reset_n,
        input test_reset_n,
        input straps,
        input ser_clk
    );

    modport supervisor (
        output board_reset_n,
        output test_reset_n,
        output straps,
        output ser_clk
    );
endinterface : reset_entry_if

//--- switch_clock_reset_entry.sv
// switch end: reset synchronizers, option capture, i2c clock divider, serial domain resets
`timescale 1ns/1ns
module switch_clock_reset_entry (
    // register clock
    input  wire logic                                ref_clk,
    // board side
    reset_entry_if.device                            link,
    // internal resets, active low
    output logic                                     reg_rst_n,
    output logic                                     fabric_rst_n,
    output logic                                     tx_rst_n,
    // test access port reset, active high
    output logic                                     tap_reset,
    // captured power-up options
    output logic [reset_entry_pkg::STRAP_W-1:0]      strap_opt,
    output logic                                     strap_valid,
    // i2c clock
    output logic                                     i2c_scl,
    output logic                                     i2c_tick
);

    // wraps a divider count back to zero after its last value
    function automatic logic [reset_entry_pkg::I2C_CNT_W-1:0] count_wrap(
        input logic [reset_entry_pkg::I2C_CNT_W-1:0] value,
        input logic [reset_entry_pkg::I2C_CNT_W-1:0] last
    );
        logic [reset_entry_pkg::I2C_CNT_W-1:0] result;
        result = (value == last) ? '0 : value + 1'b1;
        return result;
    endfunction : count_wrap

    // register clock domain reset synchronizer
    logic                                rst_meta_reg;
    logic                                rst_sync_reg;
    logic                                rst_seen_reg;
    wire                                 rst_sync_next;
    wire                                 rst_seen_next;
    wire                                 release_pulse;

    // option sampling chain
    logic [reset_entry_pkg::STRAP_W-1:0] strap_s1_reg;
    logic [reset_entry_pkg::STRAP_W-1:0] strap_s2_reg;
    logic [reset_entry_pkg::STRAP_W-1:0] strap_reg;
    logic [reset_entry_pkg::STRAP_W-1:0] strap_next;
    logic                                strap_valid_reg;
    wire                                 strap_valid_next;
    wire [reset_entry_pkg::STRAP_W-1:0]  strap_s1_next;
    wire [reset_entry_pkg::STRAP_W-1:0]  strap_s2_next;

    // i2c divider
    logic [reset_entry_pkg::I2C_CNT_W-1:0] i2c_cnt_reg;
    logic [reset_entry_pkg::I2C_CNT_W-1:0] i2c_cnt_next;
    logic                                  i2c_scl_reg;
    logic                                  i2c_tick_reg;
    wire                                   i2c_wrap;
    wire                                   i2c_scl_next;
    wire                                   i2c_rise;
    wire                                   i2c_tick_next;

    // serial reference domain reset chains, one per domain
    logic                                fabric_meta_reg;
    logic                                fabric_sync_reg;
    logic                                tx_meta_reg;
    logic                                tx_sync_reg;
    wire                                 ser_rst_n;

    // test access port reset
    logic                                tap_reset_reg;
    wire                                 tap_reset_next;

    // a release near a register clock edge may leave the first flop undecided; only the
    // second flop is read, so all logic reset by it leaves reset on one and the same edge
    assign rst_sync_next = rst_meta_reg;
    assign rst_seen_next = rst_sync_reg;

    // assertion is asynchronous, release waits two register clock edges
    always_ff @(posedge ref_clk or negedge link.board_reset_n) begin
        if (!link.board_reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_sync_next;
        end
    end

    assign reg_rst_n = rst_sync_reg;

    // remembers that the release has happened, giving a single release pulse
    always_ff @(posedge ref_clk or negedge link.board_reset_n) begin
        if (!link.board_reset_n) begin
            rst_seen_reg <= 1'b0;
        end else begin
            rst_seen_reg <= rst_seen_next;
        end
    end

    // high for the single cycle after the register domain leaves reset
    assign release_pulse = rst_sync_reg & ~rst_seen_reg;

    // options pass two flops; no setup is asked before the release edge
    always_ff @(posedge ref_clk or negedge link.board_reset_n) begin
        if (!link.board_reset_n) begin
            strap_s1_reg <= reset_entry_pkg::STRAP_RESET;
            strap_s2_reg <= reset_entry_pkg::STRAP_RESET;
        end else begin
            strap_s1_reg <= strap_s1_next;
            strap_s2_reg <= strap_s2_next;
        end
    end

    // the first sample is the edge that first sees the board reset high, so the options
    // need no setup before release; the copy then stands until the next board reset
    assign strap_s1_next    = link.straps;
    assign strap_s2_next    = strap_s1_reg;
    assign strap_next       = release_pulse ? strap_s2_reg : strap_reg;
    assign strap_valid_next = strap_valid_reg | release_pulse;

    always_ff @(posedge ref_clk or negedge link.board_reset_n) begin
        if (!link.board_reset_n) begin
            strap_reg <= reset_entry_pkg::STRAP_RESET;
        end else begin
            strap_reg <= strap_next;
        end
    end

    always_ff @(posedge ref_clk or negedge link.board_reset_n) begin
        if (!link.board_reset_n) begin
            strap_valid_reg <= 1'b0;
        end else begin
            strap_valid_reg <= strap_valid_next;
        end
    end

    assign strap_opt   = strap_reg;
    assign strap_valid = strap_valid_reg;

    // half period of 500 register clocks gives a divide by 1000
    assign i2c_wrap     = (i2c_cnt_reg == reset_entry_pkg::I2C_HALF_LAST);
    assign i2c_cnt_next  = count_wrap(i2c_cnt_reg, reset_entry_pkg::I2C_HALF_LAST);
    assign i2c_scl_next  = i2c_scl_reg ^ i2c_wrap;
    assign i2c_rise      = i2c_wrap & ~i2c_scl_reg;
    assign i2c_tick_next = i2c_rise;

    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            i2c_cnt_reg <= '0;
        end else begin
            i2c_cnt_reg <= i2c_cnt_next;
        end
    end

    // the divided clock only drives the pin; nothing inside is clocked by it
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            i2c_scl_reg <= 1'b0;
        end else begin
            i2c_scl_reg <= i2c_scl_next;
        end
    end

    // rising edge marker for i2c logic that stays on the register clock
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            i2c_tick_reg <= 1'b0;
        end else begin
            i2c_tick_reg <= i2c_tick_next;
        end
    end

    assign i2c_scl  = i2c_scl_reg;
    assign i2c_tick = i2c_tick_reg;

    // each serial reference domain leaves reset on the shared serial reference clock; assertion still follows
    // the register domain at once, release needs two serial clock edges
    assign ser_rst_n = rst_sync_reg;

    always_ff @(posedge link.ser_clk or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            fabric_meta_reg <= 1'b0;
            fabric_sync_reg <= 1'b0;
        end else begin
            fabric_meta_reg <= 1'b1;
            fabric_sync_reg <= fabric_meta_reg;
        end
    end

    always_ff @(posedge link.ser_clk or negedge ser_rst_n) begin
        if (!ser_rst_n) begin
            tx_meta_reg <= 1'b0;
            tx_sync_reg <= 1'b0;
        end else begin
            tx_meta_reg <= 1'b1;
            tx_sync_reg <= tx_meta_reg;
        end
    end

    assign fabric_rst_n = fabric_sync_reg;
    assign tx_rst_n     = tx_sync_reg;

    // test reset acts on its own pin; board reset never touches it, so a later board
    // reset without a test reset leaves the test port state alone
    assign tap_reset_next = ~link.test_reset_n;

    always_ff @(posedge ref_clk or negedge link.test_reset_n) begin
        if (!link.test_reset_n) begin
            tap_reset_reg <= 1'b1;
        end else begin
            tap_reset_reg <= tap_reset_next;
        end
    end

    assign tap_reset = tap_reset_reg;

endmodule : switch_clock_reset_entry

//--- board_reset_supervisor.sv
// supervisor end: board reset hold, test reset, option straps, serial reference clock
`timescale 1ns/1ns
module board_reset_supervisor #(
    parameter int unsigned RESET_HOLD_CYCLES = reset_entry_pkg::RESET_HOLD_CYCLES
) (
    // clock and power-good reset
    input  wire logic                                ref_clk,
    input  wire logic                                rst,
    // user requests
    input  wire logic                                reset_pulse_req,
    input  wire logic                                test_reset_src_n,
    input  wire logic [reset_entry_pkg::STRAP_W-1:0] strap_cfg,
    // status
    output logic                                     reset_active,
    output logic                                     straps_frozen,
    // board side
    reset_entry_if.supervisor                        link
);

    localparam logic [reset_entry_pkg::HOLD_CNT_W-1:0] HOLD_LAST =
        reset_entry_pkg::HOLD_CNT_W'(RESET_HOLD_CYCLES - 1);
    localparam logic [reset_entry_pkg::STRAP_CNT_W-1:0] POST_LAST =
        reset_entry_pkg::STRAP_CNT_W'(reset_entry_pkg::STRAP_HOLD_CYCLES);

    reset_entry_pkg::sup_state_t              state_reg;
    reset_entry_pkg::sup_state_t              state_next;
    logic [reset_entry_pkg::HOLD_CNT_W-1:0]   hold_cnt_reg;
    logic [reset_entry_pkg::HOLD_CNT_W-1:0]   hold_cnt_next;
    logic [reset_entry_pkg::STRAP_CNT_W-1:0]  post_cnt_reg;
    logic [reset_entry_pkg::STRAP_CNT_W-1:0]  post_cnt_next;
    logic [reset_entry_pkg::STRAP_W-1:0]      strap_reg;
    logic                                     board_n_reg;
    logic                                     test_n_reg;
    logic                                     ser_clk_reg;
    wire                                      hold_done;
    wire                                      post_done;
    wire                                      strap_load;

    assign hold_done = (hold_cnt_reg == HOLD_LAST);
    assign post_done = (post_cnt_reg == POST_LAST);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            reset_entry_pkg::SUP_HOLD: state_next = hold_done ? reset_entry_pkg::SUP_RUN
                                                              : reset_entry_pkg::SUP_HOLD;
            reset_entry_pkg::SUP_RUN:  state_next = reset_pulse_req ? reset_entry_pkg::SUP_HOLD
                                                                    : reset_entry_pkg::SUP_RUN;
            default:                   state_next = reset_entry_pkg::SUP_HOLD;
        endcase
    end

    // counting begins only out of reset, with this clock already running
    assign hold_cnt_next = (state_reg == reset_entry_pkg::SUP_HOLD) ? hold_cnt_reg + 1'b1 : '0;
    assign post_cnt_next = (state_reg == reset_entry_pkg::SUP_HOLD) ? '0 :
                           post_done ? post_cnt_reg : post_cnt_reg + 1'b1;

    // straps stop following the user one cycle before release, stay frozen ten cycles after it, then follow the user again
    assign strap_load = ((state_reg == reset_entry_pkg::SUP_HOLD) && !hold_done) ||
                        ((state_reg == reset_entry_pkg::SUP_RUN) && post_done);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= reset_entry_pkg::SUP_HOLD;
            hold_cnt_reg <= '0;
            post_cnt_reg <= '0;
        end else begin
            state_reg    <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            post_cnt_reg <= post_cnt_next;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            board_n_reg <= 1'b0;
            test_n_reg  <= 1'b0;
            strap_reg   <= reset_entry_pkg::STRAP_RESET;
            ser_clk_reg <= 1'b0;
        end else begin
            board_n_reg <= (state_next == reset_entry_pkg::SUP_RUN);
            test_n_reg  <= (state_next == reset_entry_pkg::SUP_RUN) & test_reset_src_n;
            strap_reg   <= strap_load ? strap_cfg : strap_reg;
            ser_clk_reg <= ~ser_clk_reg;
        end
    end

    assign link.board_reset_n = board_n_reg;
    assign link.test_reset_n  = test_n_reg;
    assign link.straps        = strap_reg;
    assign link.ser_clk       = ser_clk_reg;
    assign reset_active       = ~board_n_reg;
    assign straps_frozen      = ~strap_load;

endmodule : board_reset_supervisor

//--- switch_clock_reset_entry_properties.sv
// concurrent checks on the board interface and the switch reset-entry outputs
`timescale 1ns/1ns
module switch_clock_reset_entry_properties #(
    parameter int unsigned RESET_HOLD_CYCLES = reset_entry_pkg::RESET_HOLD_CYCLES
) (
    // clock and supervisor reset
    input wire logic                                ref_clk,
    input wire logic                                rst,
    // board interface
    input wire logic                                board_reset_n,
    input wire logic                                test_reset_n,
    input wire logic [reset_entry_pkg::STRAP_W-1:0] straps,
    // switch outputs
    input wire logic                                reg_rst_n,
    input wire logic                                fabric_rst_n,
    input wire logic                                tx_rst_n,
    input wire logic                                tap_reset,
    input wire logic [reset_entry_pkg::STRAP_W-1:0] strap_opt,
    input wire logic                                strap_valid,
    input wire logic                                i2c_scl,
    input wire logic                                i2c_tick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !board_reset_n);

    logic [15:0] low_cnt_reg;
    logic [9:0]  half_cnt_reg;
    logic        scl_q_reg;
    logic        scl_seen_reg;

    // board reset low time, counted per edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) low_cnt_reg <= 16'h0;
        else if (!board_reset_n) low_cnt_reg <= low_cnt_reg + 16'h1;
        else low_cnt_reg <= 16'h0;
    end

    // cycles since the last i2c clock edge
    always_ff @(posedge ref_clk or negedge board_reset_n) begin
        if (!board_reset_n) begin
            half_cnt_reg <= 10'h0;
            scl_seen_reg <= 1'b0;
        end else if (i2c_scl != scl_q_reg) begin
            half_cnt_reg <= 10'h0;
            scl_seen_reg <= 1'b1;
        end else begin
            half_cnt_reg <= half_cnt_reg + 10'h1;
        end
    end

    always_ff @(posedge ref_clk) scl_q_reg <= i2c_scl;

    sync_release_a: assert property ($rose(board_reset_n) |-> !reg_rst_n ##1 !reg_rst_n ##1 reg_rst_n)
        else $error("register reset release not two cycles after board reset");
    strap_capture_a: assert property ($rose(board_reset_n) |-> ##3 strap_valid && strap_opt == $past(straps, 3))
        else $error("options not captured at reset release");
    strap_kept_a: assert property (strap_valid |=> $stable(strap_opt) && strap_valid)
        else $error("captured options changed");
    scl_half_a: assert property ($changed(i2c_scl) && scl_seen_reg |-> half_cnt_reg == 10'h1f3)
        else $error("i2c clock half period not 500 cycles");
    scl_runs_a: assert property (half_cnt_reg <= 10'h1f8)
        else $error("i2c clock stopped");
    tick_pulse_a: assert property ($rose(i2c_scl) |-> ##[0:1] i2c_tick ##1 !i2c_tick)
        else $error("i2c tick missing or too long");
    fabric_order_a: assert property (!reg_rst_n |-> !fabric_rst_n && !tx_rst_n)
        else $error("serial domain out of reset before register domain");
    fabric_release_a: assert property ($rose(reg_rst_n) |-> ##[1:8] fabric_rst_n && tx_rst_n)
        else $error("serial domain reset not released");
    tap_set_a: assert property (!test_reset_n |-> tap_reset)
        else $error("tap reset not set by test reset");
    test_follow_a: assert property (disable iff (rst) !board_reset_n |-> !test_reset_n)
        else $error("test reset not low with board reset");
    hold_len_a: assert property ($rose(board_reset_n) |->
                                 low_cnt_reg >= RESET_HOLD_CYCLES && low_cnt_reg <= RESET_HOLD_CYCLES + 1)
        else $error("board reset hold length wrong");
    straps_hold_a: assert property ($rose(board_reset_n) |->
                                    ($stable(straps))[*8] ##1 $stable(straps) ##1 $stable(straps))
        else $error("option pins moved after release");

    cover property ($rose(strap_valid));
    cover property ($rose(i2c_tick));
    cover property ($rose(fabric_rst_n));
endmodule : switch_clock_reset_entry_properties

//--- test_switch_clock_reset_entry.sv
// bench joining the switch reset entry to the board supervisor
`timescale 1ns/1ns
module test_switch_clock_reset_entry;
    localparam int unsigned HOLD = 20;
    logic       ref_clk, rst, reset_pulse_req, test_reset_src_n;
    logic [1:0] strap_cfg, strap_opt;
    logic       reset_active, straps_frozen, reg_rst_n, fabric_rst_n, tx_rst_n;
    logic       tap_reset, strap_valid, i2c_scl, i2c_tick;
    int         fail_count, checks, n, k;

    reset_entry_if link_bus ();

    board_reset_supervisor #(.RESET_HOLD_CYCLES(HOLD)) board_reset_supervisor_inst (
        .ref_clk(ref_clk), .rst(rst), .reset_pulse_req(reset_pulse_req),
        .test_reset_src_n(test_reset_src_n), .strap_cfg(strap_cfg), .reset_active(reset_active),
        .straps_frozen(straps_frozen), .link(link_bus));

    switch_clock_reset_entry switch_clock_reset_entry_inst (
        .ref_clk(ref_clk), .link(link_bus), .reg_rst_n(reg_rst_n), .fabric_rst_n(fabric_rst_n),
        .tx_rst_n(tx_rst_n), .tap_reset(tap_reset), .strap_opt(strap_opt), .strap_valid(strap_valid),
        .i2c_scl(i2c_scl), .i2c_tick(i2c_tick));

    switch_clock_reset_entry_properties #(.RESET_HOLD_CYCLES(HOLD)) properties_inst (
        .ref_clk(ref_clk), .rst(rst), .board_reset_n(link_bus.board_reset_n),
        .test_reset_n(link_bus.test_reset_n), .straps(link_bus.straps), .reg_rst_n(reg_rst_n),
        .fabric_rst_n(fabric_rst_n), .tx_rst_n(tx_rst_n), .tap_reset(tap_reset), .strap_opt(strap_opt),
        .strap_valid(strap_valid), .i2c_scl(i2c_scl), .i2c_tick(i2c_tick));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic compare(input logic [15:0] seen, input logic [15:0] expected);
        checks++;
        if (seen !== expected) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask : compare

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // waits while a line differs from lvl, counting falling edges
    task automatic wait_level(input logic lvl, ref logic sig, inout int cnt);
        while (sig !== lvl && cnt < 3000) begin
            cnt++;
            @(negedge ref_clk);
        end
    endtask : wait_level

    task automatic settle();
        n = 0;
        while (!(strap_valid === 1'b1 && fabric_rst_n === 1'b1 && tx_rst_n === 1'b1) && n < 50) begin
            n++;
            @(negedge ref_clk);
        end
        compare({reg_rst_n, fabric_rst_n, tx_rst_n, tap_reset}, 16'he);
    endtask : settle

    task automatic board_pulse(input logic [1:0] cfg);
        strap_cfg = cfg;
        reset_pulse_req = 1'b1;
        @(negedge ref_clk);
        reset_pulse_req = 1'b0;
        compare({reg_rst_n, fabric_rst_n, tx_rst_n, strap_valid, tap_reset}, 16'h1);
        compare({reset_active, straps_frozen}, 16'h2);
        k = 0;
        wait_level(1'b1, link_bus.board_reset_n, k);
        compare(k[15:0], HOLD[15:0]);
        settle();
        compare({reset_active, straps_frozen}, 16'h1);
        compare(strap_opt, cfg);
    endtask : board_pulse

    initial begin
        rst = 1'b1;
        reset_pulse_req = 1'b0;
        test_reset_src_n = 1'b1;
        strap_cfg = 2'h2;
        fail_count = 0;
        checks = 0;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        compare(tap_reset, 16'h1);
        k = 0;
        wait_level(1'b1, link_bus.board_reset_n, k);
        settle();
        compare(strap_opt, 16'h2);
        // options move after capture; the switch must keep its copy
        strap_cfg = 2'h1;
        repeat (15) @(negedge ref_clk);
        compare(link_bus.straps, 16'h1);
        compare(straps_frozen, 16'h0);
        compare(strap_opt, 16'h2);
        k = 0;
        wait_level(1'b0, i2c_scl, k);
        wait_level(1'b1, i2c_scl, k);
        n = 0;
        wait_level(1'b0, i2c_scl, n);
        compare(n[15:0], 16'h1f4);
        wait_level(1'b1, i2c_scl, n);
        compare(n[15:0], 16'h3e8);
        for (int v = 0; v < 4; v++) board_pulse(v[1:0]);
        test_reset_src_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        compare({tap_reset, reg_rst_n}, 16'h3);
        test_reset_src_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        compare(tap_reset, 16'h0);
        give_verdict();
    end

    initial begin
        #(20000 * 100);
        fail_count++;
        give_verdict();
    end
endmodule : test_switch_clock_reset_entry
